/* File: bench/slot_sink_asserts.sv */
`timescale 1ns/1ps
module slot_sink_asserts
  import slot_sink_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  dq_data,
  input wire logic        dq_strobe,
  input wire logic [1:0]  octet_type_marker,
  input wire logic        frame_timing_mark,
  input wire logic        link_state_out,
  input wire logic [1:0]  outgoing_link_code
);
  // ------------------------------------------------
  // Control shadow
  // ------------------------------------------------
  logic [3:0] ctrl_ff;  // Last control word written
  logic [3:0] quiet_ff; // Cycles since a write; lets the octet pipe drain
  wire        settled = (quiet_ff == 4'hF);
  // The bench offers both channels in one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff  <= CTRL_RESET;
      quiet_ff <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
      quiet_ff <= 4'h0;
      if (s_axi_awaddr == CTRL_ADDR && s_axi_wstrb[0]) ctrl_ff <= s_axi_wdata[3:0];
    end else if (quiet_ff != 4'hF) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_force_code: assert property (
    settled && ctrl_ff[CTRL_FORCE] |-> !link_state_out && outgoing_link_code == LSS_LINK_DN)
    else $error("link not held down while forced");
  a_link_pair: assert property (
    link_state_out |-> outgoing_link_code == LSS_CONNECTED) else $error("up without connected");
  a_hob_code: assert property (
    settled && outgoing_link_code == LSS_HOB_INCAP |-> !ctrl_ff[CTRL_HOB] && !link_state_out)
    else $error("hob incapable code out of place");
  a_hob_empty: assert property (
    settled && ctrl_ff == 4'h9 && outgoing_link_code == LSS_LINK_DN && dq_strobe
    |-> dq_data == EMPTY_OCTET) else $error("octet not emptied under fail");
  a_inactive_ones: assert property (
    settled && !ctrl_ff[CTRL_ACTIVE] && dq_strobe |-> dq_data == ALL_ONES)
    else $error("inactive data not all ones");
  a_strobe_pulse: assert property (
    dq_strobe |=> !dq_strobe) else $error("octet strobe longer than one cycle");
  a_mark_pulse: assert property (
    frame_timing_mark |=> !frame_timing_mark [*8]) else $error("frame mark repeated");
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  c_m1: cover property (dq_strobe && octet_type_marker == TYPE_M1);
  c_hob: cover property (outgoing_link_code == LSS_HOB_INCAP);
  c_mark: cover property (frame_timing_mark);
endmodule
bind slot_sink slot_sink_asserts u_chk (.*);

/* File: bench/vc4_dqdb_slot_sink_adaptation_tb.sv */
`timescale 1ns/1ps
module vc4_dqdb_slot_sink_adaptation_tb;
  import slot_sink_pkg::*;
  logic clk = 0, rst_n = 0, trail_signal_fail_in = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ai_clk, ai_fs, dq_strobe, octet_validity_marker, frame_timing_mark;
  logic link_state_out, server_fail_out;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, ai_data, dq_data, f2_val, f3_val;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, octet_type_marker, outgoing_link_code, lss_val;
  integer seed = 32'hce8db99d;
  int miscompares = 0, check_count = 0, gap = 0, mark_gap = 0, marks = 0;
  slot_sink dut (.*);
  vc4_source src (.*);
  always #50 clk = ~clk;
  // Cycles between frame marks
  always @(posedge clk) begin
    if (frame_timing_mark) begin
      mark_gap <= gap;
      gap <= 0;
      marks <= marks + 1;
    end else gap <= gap + 1;
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check(s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [33:0] rd);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
  // Next delivered octet of a given type
  task automatic wait_type(input logic [1:0] t, output logic [7:0] d, output logic v);
    do begin
      @(posedge clk);
    end while (!(dq_strobe === 1'b1 && octet_type_marker === t));
    d = dq_data;
    v = octet_validity_marker;
  endtask
  function automatic logic [1:0] exp_code(input logic ssf, frc, hob, input logic [1:0] inc);
    if (frc || (ssf && hob)) return LSS_LINK_DN;
    if (ssf) return LSS_HOB_INCAP;
    return inc[1] ? LSS_LINK_UP : LSS_CONNECTED;
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (99000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    logic [33:0] rd;
    logic [7:0] o;
    logic v;
    f2_val = 8'($random(seed));
    f3_val = 8'($random(seed));
    lss_val = 2'($random(seed));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    check({link_state_out, outgoing_link_code}, {1'b0, LSS_LINK_DN});
    check(server_fail_out, 1);
    wait_type(TYPE_OTHER, o, v);
    check(o, ALL_ONES);
    axi_read(STATUS_ADDR, rd);
    check(rd[1:0], 0);
    axi_read(8'h0C, rd);
    check(rd, {RESP_SLVERR, 32'h0});
    axi_write(CTRL_ADDR, 32'h9);
    axi_read(CTRL_ADDR, rd);
    check(rd, 34'h9);
    wait_type(TYPE_M1, o, v);
    check({o, v}, {EMPTY_OCTET, 1'b1});
    check({link_state_out, outgoing_link_code}, {1'b0, exp_code(1, 0, 1, lss_val)});
    axi_write(CTRL_ADDR, 32'h1);
    wait_type(TYPE_M1, o, v);
    check({o, v}, {f2_val, 1'b0});
    check(outgoing_link_code, exp_code(1, 0, 0, lss_val));
    wait_type(TYPE_M2, o, v);
    check(o, f3_val);
    axi_read(STATUS_ADDR, rd);
    check({rd[5:4], rd[2], rd[0]}, {lss_val, 2'b11});
    @(posedge clk) trail_signal_fail_in <= 1'b1;
    repeat (40) @(posedge clk);
    axi_read(STATUS_ADDR, rd);
    check({rd[6], rd[0]}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      axi_write(CTRL_ADDR, {28'h0, i[0], i[1], 1'($random(seed)), 1'b1});
      repeat (3) @(posedge clk);
      check(outgoing_link_code, exp_code(1, i[1], i[0], lss_val));
    end
    @(posedge clk) trail_signal_fail_in <= 1'b0;
    axi_write(CTRL_ADDR, 32'h9);
    while (marks < 6) @(posedge clk);
    check(mark_gap >= 18790 && mark_gap <= 18792, 1);
    check({link_state_out, outgoing_link_code}, {~lss_val[1], exp_code(0, 0, 1, lss_val)});
    check(server_fail_out, 0);
    report_and_stop;
  end
endmodule

/* File: bench/vc4_source.sv */
`timescale 1ns/1ps
module vc4_source
  import slot_sink_pkg::*;
#(
  parameter logic [5:0] OFF0 = 6'h07  // First slot offset
)
(
  input  wire logic [7:0] f2_val,
  input  wire logic [7:0] f3_val,
  input  wire logic [1:0] lss_val,
  output logic            ai_clk,
  output logic [7:0]      ai_data,
  output logic            ai_fs
);
  logic [8:0] col_ff;  // Column in the container
  logic [3:0] row_ff;  // Row in the container
  logic [5:0] off_ff;  // Offset sent in this frame
  initial begin
    ai_clk = 1'b0;
    ai_data = 8'h00;
    ai_fs = 1'b0;
    col_ff = 9'h0;
    row_ff = 4'h0;
    off_ff = OFF0;
  end
  // Octet clock runs free, as a path layer clock does
  always #400 ai_clk = ~ai_clk;
  // Change on the falling edge so the sink sees settled octets
  always @(negedge ai_clk) begin
    ai_fs <= (row_ff == 4'h0) && (col_ff == 9'h0);
    if (col_ff != 9'h0) ai_data <= col_ff[7:0] ^ {row_ff, 4'hA};
    else if (row_ff == ROW_C2) ai_data <= EXPECTED_LABEL;
    // code in top bits, offset below
    else if (row_ff == ROW_H4) ai_data <= {lss_val, off_ff};
    else if (row_ff == ROW_F2) ai_data <= f2_val;
    else if (row_ff == ROW_F3) ai_data <= f3_val;
    else ai_data <= 8'h00;
    col_ff <= (col_ff == VC4_LAST_COL) ? 9'h0 : col_ff + 9'h1;
    if (col_ff == VC4_LAST_COL) row_ff <= (row_ff == VC4_LAST_ROW) ? 4'h0 : row_ff + 4'h1;
    // step by 45 modulo 53, never above 52
    if (col_ff == VC4_LAST_COL && row_ff == VC4_LAST_ROW)
      off_ff <= 6'((7'(off_ff) + 7'(SLOT_STEP)) % 7'(SLOT_LEN));
  end
endmodule

/* File: verilog/slot_sink.sv */
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Delineate slots by offset or header check
// - Header check mode correlates three header octets
// - Expected offset is previous plus 45 mod 53
// - Out of range offset counts as unexpected
// - Offset counts octets to next boundary, 0..52
// - Remove pattern 55h from header check octet
// - Descramble payload only, x^43+1, else hold
// - Type marker flags slot start, M1, M2
// - Validity marker accompanies every delivered octet
// - Frame mark each frame, plus link state
// - Accepted label not 14h raises mismatch
// - H4 bits 1-2 code, 3-8 offset
// - Codes: 00 conn, 11 dn, 01 up, 10 hob
// - F2, F3 pass unchanged as M1, M2
// - Inactive: all-ones data, no defect cause reports
// - Declare delineation loss when alignment lost
// - Server fail is tsf, mismatch or loss
// - Healthy link: UP/connected or DOWN/link_up
// - Force, or server fail with head-of-bus: DOWN, send link_dn
// - No server fail: deliver octets VALID
// - Fail with head-of-bus: EMPTY slots, M1, M2
// - Fail without head-of-bus: INVALID, send hob
// - Causes gated by tsf and mismatch
module slot_sink
  import slot_sink_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Path layer side (link clock domain, sampled)
  input  wire logic        ai_clk,
  input  wire logic [7:0]  ai_data,
  input  wire logic        ai_fs,
  input  wire logic        trail_signal_fail_in,
  // DQDB layer side
  output logic [7:0]       dq_data,
  output logic             dq_strobe,
  output logic [1:0]       octet_type_marker,
  output logic             octet_validity_marker,
  output logic             frame_timing_mark,
  output logic             link_state_out,
  output logic             server_fail_out,
  output logic [1:0]       outgoing_link_code
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] sync1;       // First stage: clk, fs, tsf, data
    logic [10:0] sync2;       // Second stage
    logic        clk_d;       // Link clock one sample back
    logic [3:0]  row;         // Row of the next octet
    logic [8:0]  col;         // Column of the next octet
    logic [5:0]  pos;         // Slot position of the next payload octet
    logic [23:0] hist;        // Last three payload octets
    logic [42:0] scr;         // Descrambler history
    delin_e      dl;          // Delineation state
    logic [2:0]  dl_cnt;      // Hysteresis counter
    logic [5:0]  prev_off;    // Last offset believed
    logic [7:0]  lbl_cand;    // Label candidate
    logic [2:0]  lbl_cnt;     // Frames the candidate has repeated
    logic [7:0]  lbl_acc;     // Accepted label
    logic [1:0]  in_code;     // Incoming link status code
    logic [3:0]  ctrl;        // Control register
    logic        aw_got;      // Write address held
    logic [7:0]  aw_addr;
    logic        w_got;       // Write data held
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  dq_data;
    logic        dq_strobe;
    logic [1:0]  dq_type;
    logic        dq_valid;
    logic        tmark;
    logic        link_up;
    logic        ssf_out;
    logic [1:0]  out_code;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Header check over three octets, generator x^8+x^2+x+1
  function automatic logic [7:0] hcs_calc(input logic [23:0] hdr);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      if (crc[7] ^ hdr[i]) begin
        crc = {crc[6:0], 1'b0} ^ HCS_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    return crc;
  endfunction

  // Self-synchronous descrambler step, MSB first; returns {history, octet}
  function automatic logic [50:0] descr(input logic [42:0] h, input logic [7:0] d);
    logic [42:0] hh;
    logic [7:0]  o;
    hh = h;
    o  = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ hh[SCR_LEN-1];
      hh   = {hh[SCR_LEN-2:0], d[i]};
    end
    return {hh, o};
  endfunction

  // Offset to slot position of the next payload octet
  function automatic logic [5:0] off_to_pos(input logic [5:0] off);
    return (off == 6'h00) ? 6'h00 : SLOT_LEN - off;
  endfunction

  // ----------------------------------------------------------------
  // Combinational decode of the current state
  // ----------------------------------------------------------------
  logic        lclk_s;
  logic        fs_s;
  logic        tsf_s;
  logic [7:0]  d_s;
  logic        octet_ev;
  logic        active;
  logic        plm;
  logic        lsd;
  logic        ssf;
  logic [6:0]  exp_sum;
  logic [5:0]  exp_off;

  always_comb begin
    {lclk_s, fs_s, tsf_s, d_s} = st_ff.sync2;
    // Octet is taken on the sampled rising edge of the link clock
    octet_ev = lclk_s & ~st_ff.clk_d;
    active   = st_ff.ctrl[CTRL_ACTIVE];
    plm      = (st_ff.lbl_acc != EXPECTED_LABEL);
    lsd      = (st_ff.dl != DL_SYNC);
    ssf      = tsf_s | plm | lsd;
    exp_sum  = {1'b0, st_ff.prev_off} + {1'b0, SLOT_STEP};
    exp_off  = (exp_sum >= {1'b0, SLOT_LEN}) ? 6'(exp_sum - {1'b0, SLOT_LEN}) : exp_sum[5:0];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0]  cr;
    logic [8:0]  cc;
    logic [5:0]  off;
    logic        off_ok;
    logic        chk;
    logic        good;
    logic [2:0]  delta;
    logic [2:0]  alpha;
    logic [7:0]  od;
    logic [1:0]  ot;
    logic        deliver;
    logic [50:0] ds;
    logic [31:0] rd;
    cr      = 4'h0;
    cc      = 9'h000;
    off     = 6'h00;
    off_ok  = 1'b0;
    chk     = 1'b0;
    good    = 1'b0;
    delta   = H4_DELTA;
    alpha   = H4_ALPHA;
    od      = EMPTY_OCTET;
    ot      = TYPE_OTHER;
    deliver = 1'b0;
    ds      = '0;
    rd      = 32'h0000_0000;
    nxt_st  = st_ff;

    // Two flip-flops on everything from the link side
    nxt_st.sync1     = {ai_clk, ai_fs, trail_signal_fail_in, ai_data};
    nxt_st.sync2     = st_ff.sync1;
    nxt_st.clk_d     = lclk_s;
    nxt_st.dq_strobe = 1'b0;
    nxt_st.tmark     = 1'b0;

    if (octet_ev) begin
      // Frame start forces the position to the first octet
      cr = fs_s ? 4'h0 : st_ff.row;
      cc = fs_s ? 9'h000 : st_ff.col;
      if (cc == VC4_LAST_COL) begin
        nxt_st.col = 9'h000;
        nxt_st.row = (cr == VC4_LAST_ROW) ? 4'h0 : cr + 4'h1;
      end else begin
        nxt_st.col = cc + 9'h001;
        nxt_st.row = cr;
      end
      if (fs_s) begin
        nxt_st.tmark   = 1'b1;
        // server fail output refreshed once per frame
        nxt_st.ssf_out = ssf;
      end

      if (cc == 9'h000) begin
        // Overhead column
        if (cr == ROW_C2) begin
          // Label accepted after it repeats in consecutive frames
          if (d_s == st_ff.lbl_cand) begin
            if (st_ff.lbl_cnt != ACCEPT_FRAMES) begin
              nxt_st.lbl_cnt = st_ff.lbl_cnt + 3'h1;
            end
            if (st_ff.lbl_cnt + 3'h1 >= ACCEPT_FRAMES) begin
              nxt_st.lbl_acc = d_s;
            end
          end else begin
            nxt_st.lbl_cand = d_s;
            nxt_st.lbl_cnt  = 3'h1;
          end
        end else if (cr == ROW_F2 || cr == ROW_F3) begin
          deliver = 1'b1;
          od      = d_s;
          ot      = (cr == ROW_F2) ? TYPE_M1 : TYPE_M2;
        end else if (cr == ROW_H4) begin
          // code in bits 1-2 (msbs), offset in bits 3-8
          nxt_st.in_code = d_s[7:6];
          off            = d_s[5:0];
          // values above 52 are never expected
          off_ok         = (off <= SLOT_LAST);
          if (!st_ff.ctrl[CTRL_HCS]) begin
            chk  = 1'b1;
            good = off_ok && ((st_ff.dl == DL_HUNT) || off == exp_off);
          end
        end
      end else begin
        // Payload octet at slot position st_ff.pos
        deliver        = 1'b1;
        nxt_st.hist    = {st_ff.hist[15:0], d_s};
        nxt_st.pos     = (st_ff.pos == SLOT_LAST) ? 6'h00 : st_ff.pos + 6'h01;
        od             = d_s;
        if (st_ff.pos == 6'h00) begin
          ot = TYPE_SLOT_START;
        end
        if (st_ff.pos == POS_HCS) begin
          od = d_s ^ HCS_COSET;
        end
        if (st_ff.pos >= POS_PAYLOAD) begin
          // descrambler advances only over payload octets
          ds         = descr(st_ff.scr, d_s);
          nxt_st.scr = ds[50:8];
          od         = ds[7:0];
        end
        if (st_ff.ctrl[CTRL_HCS]) begin
          delta = HCS_DELTA;
          alpha = HCS_ALPHA;
          // header octets correlate with the check octet
          if (st_ff.dl == DL_HUNT) begin
            chk = (hcs_calc(st_ff.hist) ^ HCS_COSET) == d_s;
            good = chk;
          end else if (st_ff.pos == POS_HCS) begin
            chk  = 1'b1;
            good = (hcs_calc(st_ff.hist) ^ HCS_COSET) == d_s;
          end
        end
      end

      // shared delineation state machine, fed by the chosen method
      if (chk) begin
        case (st_ff.dl)
          DL_HUNT: begin
            if (good) begin
              nxt_st.dl     = DL_PRESYNC;
              nxt_st.dl_cnt = 3'h1;
            end
          end
          DL_PRESYNC: begin
            if (good) begin
              nxt_st.dl_cnt = st_ff.dl_cnt + 3'h1;
              if (st_ff.dl_cnt + 3'h1 >= delta) begin
                nxt_st.dl     = DL_SYNC;
                nxt_st.dl_cnt = 3'h0;
              end
            end else begin
              nxt_st.dl     = DL_HUNT;
              nxt_st.dl_cnt = 3'h0;
            end
          end
          DL_SYNC: begin
            if (good) begin
              nxt_st.dl_cnt = 3'h0;
            end else begin
              nxt_st.dl_cnt = st_ff.dl_cnt + 3'h1;
              if (st_ff.dl_cnt + 3'h1 >= alpha) begin
                nxt_st.dl     = DL_HUNT;
                nxt_st.dl_cnt = 3'h0;
              end
            end
          end
          default: begin
            nxt_st.dl     = DL_HUNT;
            nxt_st.dl_cnt = 3'h0;
          end
        endcase
        // a believed offset reloads the slot position
        if (!st_ff.ctrl[CTRL_HCS]) begin
          if (good) begin
            nxt_st.prev_off = off;
            nxt_st.pos      = off_to_pos(off);
          end else begin
            // Missed offset: freewheel the expectation
            nxt_st.prev_off = exp_off;
          end
        end else if (good && st_ff.dl == DL_HUNT) begin
          nxt_st.pos = POS_AFTER_HCS;
        end
      end

      if (deliver) begin
        nxt_st.dq_strobe = 1'b1;
        nxt_st.dq_type   = ot;
        nxt_st.dq_valid  = 1'b1;
        nxt_st.dq_data   = od;
        if (ssf) begin
          if (st_ff.ctrl[CTRL_HOB]) begin
            // empty slots and empty management octets
            nxt_st.dq_data = EMPTY_OCTET;
          end else begin
            nxt_st.dq_valid = 1'b0;
          end
        end
        if (!active) begin
          nxt_st.dq_data = ALL_ONES;
        end
      end
    end

    // Link state, evaluated every cycle
    if (st_ff.ctrl[CTRL_FORCE] || (ssf && st_ff.ctrl[CTRL_HOB])) begin
      nxt_st.link_up  = 1'b0;
      nxt_st.out_code = LSS_LINK_DN;
    end else if (ssf) begin
      nxt_st.link_up  = 1'b0;
      nxt_st.out_code = LSS_HOB_INCAP;
    end else if (st_ff.in_code == LSS_CONNECTED || st_ff.in_code == LSS_LINK_UP) begin
      nxt_st.link_up  = 1'b1;
      nxt_st.out_code = LSS_CONNECTED;
    end else begin
      nxt_st.link_up  = 1'b0;
      nxt_st.out_code = LSS_LINK_UP;
    end

    // ---------------- Register bus: writes ----------------
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      if (st_ff.aw_addr[7:2] == CTRL_ADDR[7:2]) begin
        nxt_st.bresp = RESP_OKAY;
        if (st_ff.w_strb[0]) begin
          nxt_st.ctrl = st_ff.w_data[3:0];
        end
      end else if (st_ff.aw_addr[7:2] == STATUS_ADDR[7:2] ||
                   st_ff.aw_addr[7:2] == LABEL_ADDR[7:2]) begin
        // Read-only words ignore writes
        nxt_st.bresp = RESP_OKAY;
      end else begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // ---------------- Register bus: reads ----------------
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      if (s_axi_araddr[7:2] == CTRL_ADDR[7:2]) begin
        rd[3:0] = st_ff.ctrl;
      end else if (s_axi_araddr[7:2] == STATUS_ADDR[7:2]) begin
        // causes gated, and silent while inactive
        rd[0]   = active & plm & ~tsf_s;
        rd[1]   = active & lsd & ~tsf_s & ~plm;
        rd[2]   = ssf;
        rd[3]   = st_ff.link_up;
        rd[5:4] = st_ff.in_code;
        rd[6]   = tsf_s;
      end else if (s_axi_araddr[7:2] == LABEL_ADDR[7:2]) begin
        rd[7:0] = active ? st_ff.lbl_acc : 8'h00;
      end else begin
        nxt_st.rresp = RESP_SLVERR;
      end
      nxt_st.rdata = rd;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.dl       <= DL_HUNT;
      st_ff.ctrl     <= CTRL_RESET;
      st_ff.out_code <= LSS_LINK_DN;
      st_ff.ssf_out  <= 1'b1;
      st_ff.dq_data  <= ALL_ONES;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready terms stall a new item while one is held or answered
  assign s_axi_awready         = ~st_ff.aw_got & ~st_ff.bvalid;
  assign s_axi_wready          = ~st_ff.w_got & ~st_ff.bvalid;
  assign s_axi_arready         = ~st_ff.rvalid;
  assign s_axi_bvalid          = st_ff.bvalid;
  assign s_axi_bresp           = st_ff.bresp;
  assign s_axi_rvalid          = st_ff.rvalid;
  assign s_axi_rdata           = st_ff.rdata;
  assign s_axi_rresp           = st_ff.rresp;
  // octet type travels with each octet
  assign octet_type_marker     = st_ff.dq_type;
  assign octet_validity_marker = st_ff.dq_valid;
  assign dq_data               = st_ff.dq_data;
  assign dq_strobe             = st_ff.dq_strobe;
  assign frame_timing_mark     = st_ff.tmark;
  assign link_state_out        = st_ff.link_up;
  assign server_fail_out       = st_ff.ssf_out;
  assign outgoing_link_code    = st_ff.out_code;

endmodule

/* File: verilog/slot_sink_pkg.sv */
package slot_sink_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;  // Control word
  localparam logic [7:0] STATUS_ADDR = 8'h04;  // Defects and link state
  localparam logic [7:0] LABEL_ADDR  = 8'h08;  // Accepted signal label
  // Control bit positions
  localparam int CTRL_ACTIVE = 0;  // Activation
  localparam int CTRL_HCS    = 1;  // 1: header check method, 0: offset method
  localparam int CTRL_FORCE  = 2;  // Force link down
  localparam int CTRL_HOB    = 3;  // Head of bus capable
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Container geometry
  // ----------------------------------------------------------------
  localparam logic [8:0] VC4_LAST_COL = 9'h104;  // 261 columns
  localparam logic [3:0] VC4_LAST_ROW = 4'h8;    // 9 rows
  localparam logic [3:0] ROW_C2 = 4'h2;
  localparam logic [3:0] ROW_F2 = 4'h4;
  localparam logic [3:0] ROW_H4 = 4'h5;
  localparam logic [3:0] ROW_F3 = 4'h6;
  // ----------------------------------------------------------------
  // Slot layout
  // ----------------------------------------------------------------
  localparam logic [5:0] SLOT_LAST    = 6'h34;  // 53 octets, last index 52
  localparam logic [5:0] SLOT_LEN     = 6'h35;
  localparam logic [5:0] SLOT_STEP    = 6'h2D;  // 45
  localparam logic [5:0] POS_HCS      = 6'h03;
  localparam logic [5:0] POS_PAYLOAD  = 6'h05;
  localparam logic [5:0] POS_AFTER_HCS = 6'h04;
  localparam logic [7:0] HCS_COSET    = 8'h55;
  localparam logic [7:0] HCS_POLY     = 8'h07;
  localparam int         SCR_LEN      = 43;
  // ----------------------------------------------------------------
  // Labels, codes and markers
  // ----------------------------------------------------------------
  localparam logic [7:0] EXPECTED_LABEL = 8'h14;
  localparam logic [7:0] ALL_ONES       = 8'hFF;
  localparam logic [7:0] EMPTY_OCTET    = 8'h00;
  localparam logic [2:0] ACCEPT_FRAMES  = 3'h5;
  localparam logic [1:0] LSS_CONNECTED  = 2'h0;
  localparam logic [1:0] LSS_LINK_UP    = 2'h1;
  localparam logic [1:0] LSS_HOB_INCAP  = 2'h2;
  localparam logic [1:0] LSS_LINK_DN    = 2'h3;
  localparam logic [1:0] TYPE_OTHER     = 2'h0;
  localparam logic [1:0] TYPE_SLOT_START = 2'h1;
  localparam logic [1:0] TYPE_M1        = 2'h2;
  localparam logic [1:0] TYPE_M2        = 2'h3;
  // Delineation hysteresis (checks in a row)
  localparam logic [2:0] H4_DELTA  = 3'h2;
  localparam logic [2:0] H4_ALPHA  = 3'h3;
  localparam logic [2:0] HCS_DELTA = 3'h6;
  localparam logic [2:0] HCS_ALPHA = 3'h7;
  // Delineation states
  typedef enum logic [2:0] {
    DL_HUNT    = 3'b001,
    DL_PRESYNC = 3'b010,
    DL_SYNC    = 3'b100
  } delin_e;
endpackage
